// *** shared/io_space_pkg.sv ***
/*
 * io_space_pkg: address windows, scratch register offsets, reset values
 * and the access operation codes shared by the I/O space decoder.
 * Assumes: byte-wide registers, 8-bit data space addresses.
 */
package io_space_pkg;

   // address windows
   localparam logic [7:0] IO_FIRST = 8'h00; // first direct I/O address
   localparam logic [7:0] IO_LAST = 8'h3f; // last direct I/O address
   localparam logic [7:0] BIT_IO_LAST = 8'h1f; // last bit-accessible
   localparam logic [7:0] DATA_IO_OFFSET = 8'h20; // I/O to data offset
   localparam logic [7:0] EXT_FIRST = 8'h60; // extended window start
   localparam logic [7:0] EXT_LAST = 8'hff; // extended window end

   // scratch registers, I/O addresses
   localparam logic [7:0] SCRATCH_BYTE_0_OFFSET = 8'h19;
   localparam logic [7:0] SCRATCH_BYTE_1_OFFSET = 8'h1a;
   localparam logic [7:0] SCRATCH_BYTE_2_OFFSET = 8'h1b;
   localparam int SCRATCH_COUNT = 3; // number of scratch bytes
   localparam logic [7:0] SCRATCH_RESET = 8'h00; // value after reset

   // full byte write mask
   localparam logic [7:0] MASK_ALL = 8'hff;

   // access operations issued by the core
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      IO_READ_OP = 4'h1,
      IO_WRITE_OP = 4'h2,
      SET_IO_BIT_OP = 4'h3,
      CLEAR_IO_BIT_OP = 4'h4,
      SKIP_IF_IO_BIT_SET_OP = 4'h5,
      SKIP_IF_IO_BIT_CLEAR_OP = 4'h6,
      LOAD_INDIRECT_OP = 4'h7,
      LOAD_DIRECT_OP = 4'h8,
      LOAD_DISPLACED_OP = 4'h9,
      STORE_INDIRECT_OP = 4'ha,
      STORE_DIRECT_OP = 4'hb,
      STORE_DISPLACED_OP = 4'hc
   } access_op_t;

endpackage : io_space_pkg

// *** shared/scratch_if.sv ***
/*
 * scratch_if: carries writes and reads between the decoder and the
 * scratch byte store.
 * Assumes: both ends on the same clock.
 */
`timescale 1ns/1ns
interface scratch_if;
   logic we; // write strobe, one cycle
   logic [1:0] idx; // scratch byte index
   logic [7:0] wrData; // data for masked bits
   logic [7:0] wrMask; // bits that the write changes
   logic [7:0] rdData; // registered read of idx, one cycle later

   modport owner (output we, output idx, output wrData, output wrMask,
      input rdData);
   modport store (input we, input idx, input wrData, input wrMask,
      output rdData);
endinterface : scratch_if

// *** design/scratch_store.sv ***
/*
 * scratch_store: three general purpose byte registers with masked
 * writes and a registered read port.
 * Assumes: idx below the scratch count when we is high.
 */
`timescale 1ns/1ns
module scratch_store #(
   parameter int COUNT = io_space_pkg::SCRATCH_COUNT
) (
   input wire logic clock,
   input wire logic nrst,
   scratch_if.store port
);

   logic [7:0] bytes [COUNT]; // storage, one byte each

   // one writer process per byte, only masked bits change
   for (genvar i = 0; i < COUNT; i++) begin : g_byte
      wire hit = port.we && (port.idx == 2'(i)); // this byte written
      always_ff @(posedge clock) begin
         if (!nrst) begin
            bytes[i] <= io_space_pkg::SCRATCH_RESET;
         end else if (hit) begin
            // keep unmasked bits, take masked ones
            bytes[i] <= (bytes[i] & ~port.wrMask)
               | (port.wrData & port.wrMask);
         end
      end
   end

   // out-of-range index reads zero
   wire logic [7:0] readSel = (int'(port.idx) < COUNT) ?
      bytes[port.idx] : 8'h00;

   // read data from a register, no side effect on the store
   always_ff @(posedge clock) begin
      if (!nrst) begin
         port.rdData <= 8'h00;
      end else begin
         port.rdData <= readSel;
      end
   end

endmodule : scratch_store

// *** design/io_space_access_decoder.sv ***
/*
 * io_space_access_decoder: decodes core accesses to the peripheral
 * register space, maps direct I/O addresses into data space, runs
 * single-bit set, clear and test operations, restricts the extended
 * window, and holds the three scratch bytes.
 * Assumes: the core drives op, address, bit and data for one cycle per
 * access; peripheral read data answers periphAddr in the same cycle
 * as periphRe, from logic on this clock.
 * Limitation: reserved addresses and reserved bits are not checked;
 * keeping clear of them is the caller's duty.
 */
`timescale 1ns/1ns

// Functional notes
// - bit set/clear only on I/O 0x00..0x1F
// - bit skip tests read one low I/O bit
// - some flags clear on written one
// - bit set/clear changes only addressed bit
// - direct I/O instructions reach 0x00..0x3F only
// - data address equals I/O address plus 0x20
// - extended 0x60..0xFF only by load/store
module io_space_access_decoder (
   input wire logic clock,
   input wire logic nrst,
   // access request from the core, one cycle per access
   input wire logic reqValid,
   input wire logic [3:0] reqOp,
   input wire logic [7:0] reqAddr,
   input wire logic [2:0] reqBit,
   input wire logic [7:0] reqWrData,
   // peripheral read data, answers periphAddr in the same cycle
   input wire logic [7:0] periphRdData,
   // answer to the core, two edges after the request
   output logic ack,
   output logic [7:0] rdData,
   output logic skipTaken,
   output logic accessError,
   // peripheral register bus, one cycle after the request
   output logic periphRe,
   output logic periphWe,
   output logic [7:0] periphAddr,
   output logic [7:0] periphWrData,
   output logic [7:0] periphWrMask
);

   // operation class helpers; the load and skip classes are tested in both stages,
   // hence functions rather than repeated compares
   function automatic logic isLoad(input io_space_pkg::access_op_t o);
      return o == io_space_pkg::LOAD_INDIRECT_OP
         || o == io_space_pkg::LOAD_DIRECT_OP
         || o == io_space_pkg::LOAD_DISPLACED_OP;
   endfunction : isLoad

   function automatic logic isStore(input io_space_pkg::access_op_t o);
      return o == io_space_pkg::STORE_INDIRECT_OP
         || o == io_space_pkg::STORE_DIRECT_OP
         || o == io_space_pkg::STORE_DISPLACED_OP;
   endfunction : isStore

   function automatic logic isSkip(input io_space_pkg::access_op_t o);
      return o == io_space_pkg::SKIP_IF_IO_BIT_SET_OP
         || o == io_space_pkg::SKIP_IF_IO_BIT_CLEAR_OP;
   endfunction : isSkip

   function automatic logic isBitWr(input io_space_pkg::access_op_t o);
      return o == io_space_pkg::SET_IO_BIT_OP
         || o == io_space_pkg::CLEAR_IO_BIT_OP;
   endfunction : isBitWr

   // request operation as enum
   io_space_pkg::access_op_t op;
   assign op = io_space_pkg::access_op_t'(reqOp);

   // operation classes
   // undefined codes belong to no class and are refused below
   wire logic bitOp = isBitWr(op) || isSkip(op); // single-bit access
   wire logic directIo = op == io_space_pkg::IO_READ_OP
      || op == io_space_pkg::IO_WRITE_OP || bitOp; // I/O addressed
   wire logic dataOp = isLoad(op) || isStore(op); // data addressed
   wire logic isWrite = isStore(op) || isBitWr(op)
      || op == io_space_pkg::IO_WRITE_OP; // changes a register

   // address window checks
   wire logic inIo = reqAddr <= io_space_pkg::IO_LAST;
   wire logic inBitIo = reqAddr <= io_space_pkg::BIT_IO_LAST;
   wire logic inDataIo = reqAddr >= io_space_pkg::DATA_IO_OFFSET;
   // direct I/O legal: bit ops low window only, others full window
   wire logic ioLegal = bitOp ? inBitIo : inIo;
   wire logic legal = directIo ? ioLegal : (dataOp && inDataIo);

   // I/O address mapped into data space; direct I/O never reaches
   // the extended window since 0x3f plus 0x20 stays below 0x60
   wire logic [7:0] dataAddr = directIo ?
      8'(reqAddr + io_space_pkg::DATA_IO_OFFSET) : reqAddr;
   wire logic extHit = dataAddr >= io_space_pkg::EXT_FIRST
      && dataAddr <= io_space_pkg::EXT_LAST;
   // kept as a guard should the mapping offset ever change
   wire logic extBlocked = extHit && !dataOp;

   // I/O address of the target, for the scratch decode; the window
   // test uses the mapped data address so that direct I/O and
   // load/store reach the same three bytes
   wire logic [7:0] ioAddr = 8'(dataAddr - io_space_pkg::DATA_IO_OFFSET);
   wire logic inMappedIo = dataAddr >= io_space_pkg::DATA_IO_OFFSET;
   // scratch bytes stay inside the block, never on the peripheral bus
   wire logic scratchHit = inMappedIo
      && ioAddr >= io_space_pkg::SCRATCH_BYTE_0_OFFSET
      && ioAddr <= io_space_pkg::SCRATCH_BYTE_2_OFFSET;
   wire logic [1:0] scratchIdx =
      2'(ioAddr - io_space_pkg::SCRATCH_BYTE_0_OFFSET);

   // accepted access; refused ones still travel the pipe so that
   // every request gets exactly one ack two edges later
   wire logic go = reqValid && legal && !extBlocked;

   // bit operations touch one bit only, full writes touch all
   // (the mask, not the data, tells a peripheral what to change)
   wire logic [7:0] bitMask = 8'h01 << reqBit;
   wire logic [7:0] wrMask = isBitWr(op) ?
      bitMask : io_space_pkg::MASK_ALL;
   // set writes a one into the bit, clear a zero; a flag that clears
   // on a written one then sees a one only in its own position
   wire logic [7:0] wrValue = (op == io_space_pkg::SET_IO_BIT_OP) ?
      bitMask : (op == io_space_pkg::CLEAR_IO_BIT_OP) ?
      8'h00 : reqWrData;

   // scratch byte store
   scratch_if scr ();
   assign scr.we = go && isWrite && scratchHit;
   assign scr.idx = scratchIdx;
   assign scr.wrData = wrValue;
   assign scr.wrMask = wrMask;

   scratch_store #(
      .COUNT(io_space_pkg::SCRATCH_COUNT)
   ) u_store (
      .clock(clock),
      .nrst(nrst),
      .port(scr.store)
   );

   // hazard: a write and the next read of the same scratch byte are
   // one edge apart; the store writes at the edge that takes the
   // request, so the read one cycle later already sees the new byte
   // first stage state: the access in flight
   logic valid1; // access in stage one
   logic error1; // access refused
   logic hit1; // target is a scratch byte
   logic [2:0] bit1; // tested bit
   io_space_pkg::access_op_t op1; // operation

   // capture the request into stage one; every edge takes one,
   // there is no busy state
   always_ff @(posedge clock) begin
      if (!nrst) begin
         valid1 <= 1'b0;
         error1 <= 1'b0;
         hit1 <= 1'b0;
         bit1 <= 3'h0;
         op1 <= io_space_pkg::OP_NONE;
      end else begin
         valid1 <= reqValid;
         error1 <= reqValid && !(legal && !extBlocked);
         hit1 <= scratchHit;
         bit1 <= reqBit;
         op1 <= op;
      end
   end

   // peripheral strobes: reads for loads, I/O reads and bit tests;
   // bit set/clear is a masked write, no read-modify-write
   // refused and scratch accesses keep both strobes low, so an
   // out-of-window address never reaches a peripheral
   wire logic wantRead = go && !scratchHit && !isWrite;
   wire logic wantWrite = go && !scratchHit && isWrite;

   // drive the peripheral bus in stage one
   always_ff @(posedge clock) begin
      if (!nrst) begin
         periphRe <= 1'b0;
         periphWe <= 1'b0;
         periphAddr <= 8'h00;
         periphWrData <= 8'h00;
         periphWrMask <= 8'h00;
      end else begin
         periphRe <= wantRead;
         periphWe <= wantWrite;
         periphAddr <= dataAddr;
         periphWrData <= wrValue;
         periphWrMask <= wantWrite ? wrMask : 8'h00;
      end
   end

   // stage one read data: scratch byte or peripheral
   wire logic [7:0] readByte = hit1 ? scr.rdData : periphRdData;
   // one bit tested against the wanted level
   // a refused skip never reports a taken skip
   wire logic bitLevel = readByte[bit1];
   wire logic skipNow = valid1 && !error1 && isSkip(op1)
      && (bitLevel == (op1 == io_space_pkg::SKIP_IF_IO_BIT_SET_OP));
   // only reading accesses return data
   wire logic returnsData = isLoad(op1)
      || op1 == io_space_pkg::IO_READ_OP;

   // answer to the core in stage two
   // rdData is zero unless the access returns data, so a refused
   // or writing access never shows a stale byte
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ack <= 1'b0;
         rdData <= 8'h00;
         skipTaken <= 1'b0;
         accessError <= 1'b0;
      end else begin
         ack <= valid1;
         rdData <= (valid1 && !error1 && returnsData) ?
            readByte : 8'h00;
         skipTaken <= skipNow;
         accessError <= valid1 && error1;
      end
   end

endmodule : io_space_access_decoder

// *** tb/io_space_access_decoder_sva.sv ***
/* io_space_access_decoder_sva: port checks on the decoder.
   Assumes: bound to the decoder top, one clock, sync reset. */
`timescale 1ns/1ns
module io_space_access_decoder_sva (
   input wire logic clock,
   input wire logic nrst,
   input wire logic reqValid,
   input wire logic [3:0] reqOp,
   input wire logic [7:0] reqAddr,
   input wire logic [2:0] reqBit,
   input wire logic [7:0] reqWrData,
   input wire logic [7:0] periphRdData,
   input wire logic ack,
   input wire logic [7:0] rdData,
   input wire logic skipTaken,
   input wire logic accessError,
   input wire logic periphRe,
   input wire logic periphWe,
   input wire logic [7:0] periphAddr,
   input wire logic [7:0] periphWrData,
   input wire logic [7:0] periphWrMask
);
   // all checks on the system clock, quiet in reset
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_ACK_TWO:
      assert property (reqValid |-> ##2 ack)
      else $error("no ack two cycles after request");
   AST_IO_MAP:
      assert property (reqValid && reqOp == 4'h1 && reqAddr <= 8'h18
         |=> periphRe && periphAddr == $past(reqAddr) + 8'h20)
      else $error("io read not mapped to data address");
   AST_BIT_MASK:
      assert property (reqValid && reqOp == 4'h3 && reqAddr <= 8'h18
         |=> periphWe && periphWrMask == (8'h01 << $past(reqBit))
         && periphWrData == periphWrMask)
      else $error("bit set touches other bits");
   AST_BIT_RANGE:
      assert property (reqValid && reqOp inside {4'h3, 4'h4}
         && reqAddr > 8'h1f |=> !periphWe ##1 accessError)
      else $error("bit op above low range not refused");
   AST_IO_HIGH:
      assert property (reqValid && reqOp inside {4'h1, 4'h2}
         && reqAddr > 8'h3f |=> !periphRe && !periphWe ##1 accessError)
      else $error("io access above range not refused");
   AST_EXT_LOAD:
      assert property (reqValid && reqOp inside {[4'h7:4'h9]}
         && reqAddr >= 8'h60
         |=> periphRe && periphAddr == $past(reqAddr) ##1 !accessError)
      else $error("load in extended window mishandled");
   AST_SKIP_ACK:
      assert property (skipTaken |-> ack && !accessError)
      else $error("skip result without clean ack");
   AST_SCRATCH_LOCAL:
      assert property (periphRe || periphWe
         |-> !(periphAddr inside {[8'h39:8'h3b]}))
      else $error("scratch access leaked to peripherals");
   AST_ERR_QUIET:
      assert property (accessError |-> ack && rdData == 8'h00)
      else $error("refusal without ack or with data");
endmodule : io_space_access_decoder_sva

bind io_space_access_decoder io_space_access_decoder_sva u_sva (
   .clock(clock), .nrst(nrst), .reqValid(reqValid), .reqOp(reqOp),
   .reqAddr(reqAddr), .reqBit(reqBit), .reqWrData(reqWrData),
   .periphRdData(periphRdData), .ack(ack), .rdData(rdData),
   .skipTaken(skipTaken), .accessError(accessError),
   .periphRe(periphRe), .periphWe(periphWe), .periphAddr(periphAddr),
   .periphWrData(periphWrData), .periphWrMask(periphWrMask));

// *** tb/periph_model.sv ***
/* periph_model: peripheral registers behind the decoder strobes.
   Assumes: masked writes; data 0x22 is a write-one-to-clear flag byte. */
`timescale 1ns/1ns
module periph_model (
   input wire logic clock,
   input wire logic periphRe,
   input wire logic periphWe,
   input wire logic [7:0] periphAddr,
   input wire logic [7:0] periphWrData,
   input wire logic [7:0] periphWrMask,
   output logic [7:0] periphRdData
);
   logic [7:0] mem [256]; // register contents
   logic [7:0] lastRd; // last byte answered
   logic [7:0] hit; // written ones under the mask
   // flags start pending so a stray write-back would show
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      mem[8'h22] = 8'hff;
      lastRd = 8'h00;
   end
   assign hit = periphWrData & periphWrMask;
   // flag byte clears on ones, others change masked bits only
   always @(posedge clock) begin
      if (periphWe && periphAddr == 8'h22) begin
         mem[8'h22] <= mem[8'h22] & ~hit;
      end else if (periphWe) begin
         mem[periphAddr] <= (mem[periphAddr] & ~periphWrMask) | hit;
      end
      if (periphRe) begin
         lastRd <= mem[periphAddr];
      end
   end
   // bus not selected shows the inverse of the last answer
   assign periphRdData = periphRe ? mem[periphAddr] : ~lastRd;
endmodule : periph_model

// *** tb/io_space_access_decoder_bench.sv ***
/* io_space_access_decoder_bench: drives core accesses, checks answers.
   Assumes: two-cycle ack, peripheral model on the strobes. */
`timescale 1ns/1ns
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("MISMATCH %s exp %h got %h", what, exp, got); \
      end \
   end
module io_space_access_decoder_bench;
   logic clock, nrst, reqValid, ack, skipTaken, accessError;
   logic periphRe, periphWe, gotSkip, gotErr;
   logic [3:0] reqOp;
   logic [2:0] reqBit;
   logic [7:0] reqAddr, reqWrData, periphRdData, rdData, periphAddr;
   logic [7:0] periphWrData, periphWrMask, gotRd;
   logic [7:0] pat = 8'h27; // scratch 0 after the bit ops
   int error_cnt = 0;
   int n_compared = 0;

   io_space_access_decoder u_io_space_access_decoder (.clock(clock),
      .nrst(nrst), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqBit(reqBit), .reqWrData(reqWrData), .periphRdData(periphRdData),
      .ack(ack), .rdData(rdData), .skipTaken(skipTaken),
      .accessError(accessError), .periphRe(periphRe), .periphWe(periphWe),
      .periphAddr(periphAddr), .periphWrData(periphWrData),
      .periphWrMask(periphWrMask));
   periph_model u_periph_model (.clock(clock), .periphRe(periphRe),
      .periphWe(periphWe), .periphAddr(periphAddr),
      .periphWrData(periphWrData), .periphWrMask(periphWrMask),
      .periphRdData(periphRdData));

   // prints counts and verdict, ends the run
   task automatic wrap_up();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   // one access: request for one cycle, then wait a bounded time for ack
   task automatic acc(input logic [3:0] op, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] d);
      reqValid = 1'b1;
      reqOp = op;
      reqAddr = a;
      reqBit = b;
      reqWrData = d;
      @(posedge clock);
      #2 reqValid = 1'b0;
      for (int n = 0; n < 4 && ack !== 1'b1; n++) begin
         @(posedge clock);
         #2;
      end
      `CHK("ack", 1'b1, ack)
      gotRd = rdData;
      gotSkip = skipTaken;
      gotErr = accessError;
   endtask : acc

   // free running system clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // hang guard
   initial begin
      #(50 * 2000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      nrst = 1'b0;
      reqValid = 1'b0;
      reqOp = 4'h0;
      reqAddr = 8'h00;
      reqBit = 3'h0;
      reqWrData = 8'h00;
      repeat (2) @(posedge clock);
      #2 nrst = 1'b1;
      // scratch bytes: reset value, write by io, read by data address
      for (int i = 0; i < 3; i++) begin
         acc(4'h1, 8'h19 + 8'(i), 3'h0, 8'h00);
         `CHK("scratch reset", io_space_pkg::SCRATCH_RESET, gotRd)
         acc(4'h2, 8'h19 + 8'(i), 3'h0, 8'ha5 ^ 8'(i));
         acc(4'h8, 8'h39 + 8'(i), 3'h0, 8'h00);
         `CHK("scratch data", 8'ha5 ^ 8'(i), gotRd)
      end
      // single bit set and clear, then every bit tested both ways
      acc(4'h3, 8'h19, 3'h1, 8'h00);
      acc(4'h4, 8'h19, 3'h7, 8'h00);
      acc(4'h1, 8'h19, 3'h0, 8'h00);
      `CHK("bit ops", pat, gotRd)
      for (int b = 0; b < 8; b++) begin
         acc(4'h5, 8'h19, 3'(b), 8'h00);
         `CHK("skip set", pat[b], gotSkip)
         acc(4'h6, 8'h19, 3'(b), 8'h00);
         `CHK("skip clear", ~pat[b], gotSkip)
      end
      // flag byte: a set clears one flag, a clear leaves the rest pending
      acc(4'h3, 8'h02, 3'h2, 8'h00);
      acc(4'h4, 8'h02, 3'h0, 8'h00);
      acc(4'h1, 8'h02, 3'h0, 8'h00);
      `CHK("flag byte", 8'hfb, gotRd)
      // top of the bit window reaches a peripheral, skip tests it there
      acc(4'h3, 8'h1f, 3'h3, 8'h00);
      `CHK("bit top err", 1'b0, gotErr)
      acc(4'h5, 8'h1f, 3'h3, 8'h00);
      `CHK("skip periph", 1'b1, gotSkip)
      acc(4'h1, 8'h1f, 3'h0, 8'h00);
      `CHK("bit top", 8'h08, gotRd)
      // top io address through a peripheral, read back by load
      acc(4'h2, 8'h3f, 3'h0, 8'h5a);
      acc(4'h7, 8'h5f, 3'h0, 8'h00);
      `CHK("io top", 8'h5a, gotRd)
      // extended window by every store and load kind
      for (int k = 0; k < 3; k++) begin
         acc(4'ha + 4'(k), 8'h80 + 8'(k), 3'h0, 8'h30 + 8'(k));
         `CHK("ext err", 1'b0, gotErr)
         acc(4'h7 + 4'(k), 8'h80 + 8'(k), 3'h0, 8'h00);
         `CHK("ext data", 8'h30 + 8'(k), gotRd)
      end
      // every code just outside its window, or undefined, is refused
      for (int op = 0; op < 16; op++) begin
         acc(4'(op), (op == 1 || op == 2) ? 8'h40 :
            (op >= 3 && op <= 6) ? 8'h20 : 8'h1f, 3'h0, 8'h00);
         `CHK("refused", 1'b1, gotErr)
      end
      wrap_up();
   end
endmodule : io_space_access_decoder_bench
